//--- rtl/tiv_top.sv
// interrupt vector control: request gating, priority select, vectors, ahb registers
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module tiv_top
    import tiv_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    // ahb-lite slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    // controller and clock requests (pins)
    input wire logic [NUM_CTRL-1:0] I_CTRL_IRQ,
    input wire logic I_RTC_IRQ,
    // processor sequencing
    input wire logic I_INSTR_END,
    input wire logic I_DI_INSTR,
    input wire logic I_EI_INSTR,
    input wire logic I_WAIT_INSTR,
    input wire logic I_AUTO_EXEC,
    input wire logic I_COMP_INT,
    input wire logic I_EXT_EXEC,
    input wire logic I_EXEC_N,
    input wire logic I_IO_OPCODE_N,
    input wire logic [DEC_IN_W-1:0] I_OPERAND_N,
    output logic O_INT_TAKE,
    output var tiv_vector_t O_VECTOR,
    output logic O_SAVE_EN,
    output logic [ADDR_W-1:0] O_SAVE_ADDR,
    output logic O_RTC_SEL_CLK,
    output logic O_IO_SEL_CLK,
    output logic [DEC_OUT_W-1:0] O_CTRL_SEL
);
    // ==========================================
    // pin synchronisers
    localparam int NREQ = NUM_CTRL + 1;
    logic [NREQ-1:0] req_pin;
    logic [NREQ-1:0] s1_reg;
    logic [NREQ-1:0] s2_reg;
    logic [NREQ-1:0] s3_reg;
    logic [NREQ-1:0] req_reg;

    assign req_pin = {I_RTC_IRQ, I_CTRL_IRQ};

    genvar g;
    generate
        for (g = 0; g < NREQ; g++) begin : g_sync
            always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
                if (!I_RESET_N) begin
                    s1_reg[g] <= 1'b0;
                    s2_reg[g] <= 1'b0;
                    s3_reg[g] <= 1'b0;
                    req_reg[g] <= 1'b0;
                end else begin
                    s1_reg[g] <= req_pin[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                    if (s2_reg[g] == s3_reg[g]) begin
                        req_reg[g] <= s3_reg[g];
                    end
                end
            end
        end
    endgenerate

    // ==========================================
    // registers
    logic [NUM_CTRL-1:0] mask_reg;
    logic gate_reg;
    logic rtc_mask_reg;
    logic enable_reg;
    logic ahb_wr_reg;
    logic [7:0] ahb_addr_reg;
    logic sw_ei;
    logic sw_di;
    logic addr_phase;
    logic [31:0] rdata_next;
    tiv_state_t state_reg;
    tiv_vector_t vector_reg;
    logic [SEL_W-1:0] ptr_reg;

    assign addr_phase = I_HSEL & I_HREADY & (I_HTRANS == HTRANS_NONSEQ);
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = HRESP_OKAY;

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ahb_wr_reg <= 1'b0;
            ahb_addr_reg <= '0;
        end else begin
            ahb_wr_reg <= addr_phase & I_HWRITE;
            ahb_addr_reg <= addr_phase ? I_HADDR[7:0] : ahb_addr_reg;
        end
    end

    assign sw_ei = ahb_wr_reg & (ahb_addr_reg == REG_CMD_OFS) & I_HWDATA[CMD_EI_BIT];
    assign sw_di = ahb_wr_reg & (ahb_addr_reg == REG_CMD_OFS) & I_HWDATA[CMD_DI_BIT];

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            mask_reg <= MASK_RESET;
            gate_reg <= GATE_RESET;
            rtc_mask_reg <= RTC_MASK_RESET;
        end else if (ahb_wr_reg && ahb_addr_reg == REG_MASK_OFS) begin
            mask_reg <= I_HWDATA[NUM_CTRL-1:0];
            gate_reg <= I_HWDATA[MASK_GATE_BIT];
            rtc_mask_reg <= I_HWDATA[MASK_RTC_BIT];
        end
    end

    always_comb begin
        rdata_next = '0;
        unique case (I_HADDR[7:0])
            REG_CMD_OFS: rdata_next[0] = enable_reg;
            REG_MASK_OFS: begin
                rdata_next[NUM_CTRL-1:0] = mask_reg;
                rdata_next[MASK_GATE_BIT] = gate_reg;
                rdata_next[MASK_RTC_BIT] = rtc_mask_reg;
            end
            REG_STATUS_OFS: begin
                rdata_next[0] = enable_reg;
                rdata_next[1] = (state_reg == TIV_ACTIVE);
                rdata_next[6:4] = ptr_reg;
                rdata_next[16:8] = req_reg;
            end
            REG_VECTOR_OFS: rdata_next[16:0] = vector_reg;
            default: rdata_next = '0;
        endcase
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_HRDATA <= '0;
        end else if (addr_phase && !I_HWRITE) begin
            O_HRDATA <= rdata_next;
        end
    end

    // ==========================================
    // priority select clock
    logic [SEL_DIV_W-1:0] div_reg;
    logic div_tick;
    logic sel_clk;
    logic rtc_raised;

    assign div_tick = (div_reg == SEL_DIV_W'(SEL_CLK_CYCLES - 1));

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_tick ? '0 : div_reg + 1'b1;
        end
    end

    assign sel_clk = div_tick & ~gate_reg;
    assign O_RTC_SEL_CLK = sel_clk & ~I_WAIT_INSTR & ~I_AUTO_EXEC;
    assign rtc_raised = req_reg[NUM_CTRL] & ~rtc_mask_reg;
    assign O_IO_SEL_CLK = O_RTC_SEL_CLK & ~rtc_raised;

    // circulating start point for the controller scan
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ptr_reg <= '0;
        end else if (O_IO_SEL_CLK) begin
            ptr_reg <= ptr_reg + 1'b1;
        end
    end

    // ==========================================
    // request gating and selection
    logic [NUM_CTRL-1:0] live;
    logic any_pending;
    logic found;
    logic [SEL_W-1:0] pick;
    logic [SEL_W-1:0] idx;

    assign live = req_reg[NUM_CTRL-1:0] & ~mask_reg;
    assign any_pending = (|live) | rtc_raised;

    always_comb begin
        found = 1'b0;
        pick = '0;
        idx = '0;
        for (int k = 0; k < NUM_CTRL; k++) begin
            idx = ptr_reg + SEL_W'(k);
            if (!found && live[idx]) begin
                found = 1'b1;
                pick = idx;
            end
        end
    end

    // ==========================================
    // acceptance sequence
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_reg <= TIV_RUN;
        end else begin
            unique case (state_reg)
                TIV_RUN: begin
                    if (I_INSTR_END && enable_reg && any_pending) begin
                        state_reg <= TIV_TAKE;
                    end
                end
                TIV_TAKE: state_reg <= TIV_ACTIVE;
                TIV_ACTIVE: begin
                    if (I_COMP_INT) begin
                        state_reg <= TIV_RUN;
                    end
                end
            endcase
        end
    end

    // enable: the enable instruction or a command-register EI write sets it, except in TIV_ACTIVE; any clear wins
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            enable_reg <= 1'b0;
        end else if (I_DI_INSTR || sw_di || state_reg == TIV_TAKE) begin
            enable_reg <= 1'b0;
        end else if ((I_EI_INSTR || sw_ei) && state_reg != TIV_ACTIVE) begin
            enable_reg <= 1'b1;
        end
    end

    // vector latched at the boundary; highest priority is the clock unit
    logic [ADDR_W-1:0] gen_addr;
    logic [SEL_W-1:0] gen_src;

    assign gen_src = rtc_raised ? '0 : pick;

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            vector_reg <= '0;
        end else if (state_reg == TIV_RUN && I_INSTR_END && enable_reg && any_pending) begin
            vector_reg.valid <= 1'b1;
            vector_reg.from_rtc <= rtc_raised;
            vector_reg.source <= gen_src;
            vector_reg.addr <= gen_addr;
        end else if (state_reg == TIV_ACTIVE && I_COMP_INT) begin
            vector_reg.valid <= 1'b0;
        end
    end

    assign O_VECTOR = vector_reg;
    assign O_INT_TAKE = (state_reg == TIV_TAKE);

    tiv_vector_gen u_vec (
        .i_source(gen_src),
        .i_from_rtc(rtc_raised),
        .i_comp_int(I_COMP_INT),
        .i_ext_exec(I_EXT_EXEC),
        .i_int_active(state_reg == TIV_ACTIVE),
        .o_vec_addr(gen_addr),
        .o_save_en(O_SAVE_EN),
        .o_save_addr(O_SAVE_ADDR)
    );

    tiv_ctrl_decoder u_dec (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RESET_N),
        .i_operand_n(I_OPERAND_N),
        .i_exec_n(I_EXEC_N),
        .i_io_opcode_n(I_IO_OPCODE_N),
        .o_select(O_CTRL_SEL)
    );
endmodule // tiv_top
`default_nettype wire

//--- rtl/tiv_pkg.sv
// package: constants and types for the terminal interrupt vector control
package tiv_pkg;

    // ==========================================
    // sizes
    localparam int NUM_CTRL = 8;
    localparam int SEL_W = 3;
    localparam int ADDR_W = 12;
    localparam int DEC_IN_W = 4;
    localparam int DEC_OUT_W = 16;

    // ==========================================
    // special addresses
    localparam logic [ADDR_W-1:0] VEC_BASE = 12'hff0;
    localparam logic [ADDR_W-1:0] SAVE_AREA_ADDR = 12'hff8;
    localparam logic [ADDR_W-1:0] RTC_VEC_ADDR = 12'hfc0;
    localparam logic [5:0] VEC_TOP_ONES = 6'h3f;
    localparam logic [2:0] FIRST_LOW_BIT5 = 3'h5;

    // ==========================================
    // register map (byte offsets)
    localparam logic [7:0] REG_CMD_OFS = 8'h00;
    localparam logic [7:0] REG_MASK_OFS = 8'h04;
    localparam logic [7:0] REG_STATUS_OFS = 8'h08;
    localparam logic [7:0] REG_VECTOR_OFS = 8'h0c;
    localparam int CMD_EI_BIT = 0;
    localparam int CMD_DI_BIT = 1;
    localparam int MASK_GATE_BIT = 8;
    localparam int MASK_RTC_BIT = 9;
    localparam logic [7:0] MASK_RESET = 8'hff;
    localparam logic GATE_RESET = 1'b1;
    localparam logic RTC_MASK_RESET = 1'b1;

    // ==========================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SEL_CLK_PERIOD_NS = 1000;
    localparam int SEL_CLK_CYCLES = (SEL_CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEL_DIV_W = 7;

    // ==========================================
    // ahb
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef struct packed {
        logic valid;
        logic from_rtc;
        logic [SEL_W-1:0] source;
        logic [ADDR_W-1:0] addr;
    } tiv_vector_t;

    typedef enum logic [1:0] {
        TIV_RUN = 2'b00,
        TIV_TAKE = 2'b01,
        TIV_ACTIVE = 2'b10
    } tiv_state_t;

endpackage

//--- rtl/tiv_vector_gen.sv
// special status-area and save-area address generator
`timescale 1ns/10ps
`default_nettype none
module tiv_vector_gen
    import tiv_pkg::*;
(
    input wire logic [SEL_W-1:0] i_source,
    input wire logic i_from_rtc,
    input wire logic i_comp_int,
    input wire logic i_ext_exec,
    input wire logic i_int_active,
    output logic [ADDR_W-1:0] o_vec_addr,
    output logic o_save_en,
    output logic [ADDR_W-1:0] o_save_addr
);
    logic [ADDR_W-1:0] step;
    logic [ADDR_W-1:0] ctrl_addr;

    // four bytes per controller, counting down from the base
    assign step = {{(ADDR_W-SEL_W-2){1'b0}}, i_source, 2'b00};
    assign ctrl_addr = VEC_BASE - step;

    always_comb begin
        o_vec_addr = ctrl_addr;
        o_vec_addr[ADDR_W-1:6] = VEC_TOP_ONES;
        o_vec_addr[5] = (i_source >= FIRST_LOW_BIT5) ? 1'b0 : 1'b1;
        o_vec_addr[1:0] = 2'b00;
        if (i_from_rtc) begin
            o_vec_addr = RTC_VEC_ADDR;
        end
    end

    assign o_save_en = i_comp_int | (i_ext_exec & i_int_active);
    assign o_save_addr = o_save_en ? SAVE_AREA_ADDR : '0;
endmodule // tiv_vector_gen
`default_nettype wire

//--- rtl/tiv_ctrl_decoder.sv
// four-to-sixteen controller select decoder
`timescale 1ns/10ps
`default_nettype none
module tiv_ctrl_decoder
    import tiv_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [DEC_IN_W-1:0] i_operand_n,
    input wire logic i_exec_n,
    input wire logic i_io_opcode_n,
    output logic [DEC_OUT_W-1:0] o_select
);
    logic [DEC_IN_W-1:0] index;
    logic enable;

    assign index = ~i_operand_n;
    assign enable = ~i_exec_n & ~i_io_opcode_n;

    // output 15 is the real-time clock; others go to the jumper blocks
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_select <= '0;
        end else begin
            o_select <= enable ? (16'h0001 << index) : '0;
        end
    end
endmodule // tiv_ctrl_decoder
`default_nettype wire

//--- tb/tiv_ctrl_model.sv
// model of the controller boards and the real-time clock
`timescale 1ns/10ps
`default_nettype none
module tiv_far_model
    import tiv_pkg::*;
(
    input wire logic [NUM_CTRL-1:0] i_want,
    input wire logic i_rtc_want,
    output logic [NUM_CTRL-1:0] o_irq,
    output logic o_rtc_irq
);
    // i_want is indexed by connector; connector c is strapped to address NUM_CTRL-1-c
    always_comb begin
        for (int c = 0; c < NUM_CTRL; c++) begin
            o_irq[NUM_CTRL-1-c] = i_want[c];
        end
        o_rtc_irq = i_rtc_want;
    end
endmodule // tiv_far_model
`default_nettype wire

//--- tb/tiv_asserts.sv
// port assertions for the interrupt vector control
`timescale 1ns/10ps
`default_nettype none
module tiv_asserts
    import tiv_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    input wire logic I_WAIT_INSTR,
    input wire logic I_AUTO_EXEC,
    input wire logic I_COMP_INT,
    input wire logic I_EXEC_N,
    input wire logic I_IO_OPCODE_N,
    input wire logic [DEC_IN_W-1:0] I_OPERAND_N,
    input wire logic O_INT_TAKE,
    input wire tiv_vector_t O_VECTOR,
    input wire logic O_SAVE_EN,
    input wire logic [ADDR_W-1:0] O_SAVE_ADDR,
    input wire logic O_RTC_SEL_CLK,
    input wire logic O_IO_SEL_CLK,
    input wire logic [DEC_OUT_W-1:0] O_CTRL_SEL
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESET_N);
    // ==========
    // vectors
    sequence s_ctrl_vec;
        O_VECTOR.valid && !O_VECTOR.from_rtc;
    endsequence
    property p_take_vec; O_INT_TAKE |-> O_VECTOR.valid; endproperty
    a_take_vec: assert property (p_take_vec) else $error("take without vector");
    property p_top; O_VECTOR.valid |-> O_VECTOR.addr[11:6] == 6'h3f; endproperty
    a_top: assert property (p_top) else $error("vector top bits");
    property p_bit5; s_ctrl_vec |-> O_VECTOR.addr[5] == (O_VECTOR.source < 3'h5); endproperty
    a_bit5: assert property (p_bit5) else $error("vector bit five");
    property p_addr;
        s_ctrl_vec |-> O_VECTOR.addr == 12'hff0 - {7'h0, O_VECTOR.source, 2'b00};
    endproperty
    a_addr: assert property (p_addr) else $error("vector address");
    property p_hold; O_VECTOR.valid && !I_COMP_INT |=> O_VECTOR.valid && $stable(O_VECTOR.addr);
    endproperty
    a_hold: assert property (p_hold) else $error("vector not held");
    property p_save; I_COMP_INT |-> O_SAVE_EN && O_SAVE_ADDR == 12'hff8; endproperty
    a_save: assert property (p_save) else $error("save address");
    // ==========
    // select clock and decoder
    property p_inhibit;
        (I_WAIT_INSTR || I_AUTO_EXEC)[*3] |-> !O_RTC_SEL_CLK && !O_IO_SEL_CLK;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("select clock not inhibited");
    property p_io_sel; O_IO_SEL_CLK |-> O_RTC_SEL_CLK; endproperty
    a_io_sel: assert property (p_io_sel) else $error("io select alone");
    property p_dec;
        1'b1 |=> O_CTRL_SEL == ((!$past(I_EXEC_N) && !$past(I_IO_OPCODE_N)) ?
            16'h1 << ~$past(I_OPERAND_N) : 16'h0);
    endproperty
    a_dec: assert property (p_dec) else $error("decoder output");
endmodule // tiv_asserts
bind tiv_top tiv_asserts u_asserts (.I_REF_CLK, .I_RESET_N, .I_WAIT_INSTR, .I_AUTO_EXEC,
    .I_COMP_INT, .I_EXEC_N, .I_IO_OPCODE_N, .I_OPERAND_N, .O_INT_TAKE, .O_VECTOR, .O_SAVE_EN,
    .O_SAVE_ADDR, .O_RTC_SEL_CLK, .O_IO_SEL_CLK, .O_CTRL_SEL);
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the interrupt vector control
`timescale 1ns/10ps
`default_nettype none
module tb import tiv_pkg::*;;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
    logic [1:0] htrans = HTRANS_IDLE;
    logic [NUM_CTRL-1:0] want = '0, irq;
    logic rtc_want = 1'b0, rtc_irq, got, take, save_en, rsel, iosel;
    logic iend = 1'b0, di = 1'b0, ei = 1'b0, wt = 1'b0, ax = 1'b0, comp = 1'b0;
    logic exec_n = 1'b1, io_n = 1'b1, ext = 1'b0;
    logic [3:0] opn = 4'hf;
    logic [11:0] save_addr;
    logic [15:0] csel;
    tiv_vector_t vec;
    int err_count = 0, check_count = 0, cyc = 0, r, io, n;
    initial forever #5 clk = ~clk;
    tiv_far_model u_far (.i_want(want), .i_rtc_want(rtc_want), .o_irq(irq), .o_rtc_irq(rtc_irq));
    tiv_top dut (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
        .I_HREADY(hreadyout), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp),
        .I_CTRL_IRQ(irq), .I_RTC_IRQ(rtc_irq), .I_INSTR_END(iend), .I_DI_INSTR(di),
        .I_EI_INSTR(ei), .I_WAIT_INSTR(wt), .I_AUTO_EXEC(ax), .I_COMP_INT(comp),
        .I_EXT_EXEC(ext), .I_EXEC_N(exec_n), .I_IO_OPCODE_N(io_n), .I_OPERAND_N(opn),
        .O_INT_TAKE(take), .O_VECTOR(vec), .O_SAVE_EN(save_en), .O_SAVE_ADDR(save_addr),
        .O_RTC_SEL_CLK(rsel), .O_IO_SEL_CLK(iosel), .O_CTRL_SEL(csel));
    // ==========
    // tasks
    task summarize;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= HTRANS_IDLE;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task boundary;
        repeat (8) @(posedge clk);
        iend <= 1'b1;
        @(posedge clk);
        iend <= 1'b0;
        got = 1'b0;
        repeat (6) begin
            @(posedge clk);
            if (take !== 1'b0) got = 1'b1;
        end
    endtask
    task count_sel(input int lead);
        repeat (lead) @(posedge clk);
        r = 0;
        io = 0;
        repeat (300) begin
            @(posedge clk);
            r += (rsel !== 1'b0);
            io += (iosel !== 1'b0);
        end
    endtask
    task finish_int;
        want <= '0;
        ext <= 1'b1;
        @(posedge clk);
        chk({save_en, save_addr}, {1'b1, 12'hff8});
        ext <= 1'b0;
        comp <= 1'b1;
        @(posedge clk);
        chk({save_en, save_addr}, {1'b1, 12'hff8});
        comp <= 1'b0;
        ext <= 1'b1;
        @(posedge clk);
        chk({save_en, save_addr}, 32'h0);
        ext <= 1'b0;
    endtask
    // ==========
    // sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, REG_MASK_OFS, 32'h0);
        chk(q, 32'h3ff);
        chk({hreadyout, hresp}, {1'b1, HRESP_OKAY});
        bus(1'b0, REG_CMD_OFS, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 8'h40, 32'hffffffff);
        bus(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        $display("test reset done");
        for (int s = 0; s < NUM_CTRL; s++) begin
            bus(1'b1, REG_MASK_OFS, 32'h3ff & ~(32'h1 << s));
            bus(1'b1, REG_CMD_OFS, 32'h1);
            want[NUM_CTRL-1-s] <= 1'b1;
            boundary;
            chk(got, 32'h1);
            chk(vec, {2'b10, s[2:0], 12'hff0 - 12'(4 * s)});
            bus(1'b0, REG_VECTOR_OFS, 32'h0);
            chk(q, {15'h0, 2'b10, s[2:0], 12'hff0 - 12'(4 * s)});
            bus(1'b0, REG_STATUS_OFS, 32'h0);
            chk(q, 32'h2 | (32'h1 << (8 + s)));
            bus(1'b0, REG_CMD_OFS, 32'h0);
            chk(q, 32'h0);
            ei <= 1'b1;
            @(posedge clk);
            ei <= 1'b0;
            finish_int;
            want[NUM_CTRL-1-s] <= 1'b1;
            boundary;
            chk(got, 32'h0);
            want <= '0;
        end
        $display("test vectors done");
        bus(1'b1, REG_MASK_OFS, 32'h3ff);
        bus(1'b1, REG_CMD_OFS, 32'h1);
        want <= 8'hff;
        boundary;
        chk(got, 32'h0);
        bus(1'b1, REG_MASK_OFS, 32'h300);
        n = 0;
        repeat (20) begin
            @(posedge clk);
            n += (take !== 1'b0);
        end
        chk(n, 32'h0);
        bus(1'b1, REG_CMD_OFS, 32'h3);
        bus(1'b0, REG_CMD_OFS, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, REG_CMD_OFS, 32'h1);
        bus(1'b0, REG_CMD_OFS, 32'h0);
        chk(q, 32'h1);
        di <= 1'b1;
        @(posedge clk);
        di <= 1'b0;
        boundary;
        chk(got, 32'h0);
        bus(1'b1, REG_MASK_OFS, 32'h100);
        ei <= 1'b1;
        @(posedge clk);
        ei <= 1'b0;
        want <= 8'hff;
        rtc_want <= 1'b1;
        boundary;
        chk({vec.valid, vec.from_rtc, vec.addr}, {2'b11, RTC_VEC_ADDR});
        finish_int;
        $display("test gating done");
        count_sel(0);
        chk(r, 32'h0);
        bus(1'b1, REG_MASK_OFS, 32'h0);
        count_sel(150);
        chk(r, 32'h3);
        chk(io, 32'h0);
        rtc_want <= 1'b0;
        count_sel(20);
        chk(io, 32'h3);
        wt <= 1'b1;
        count_sel(0);
        chk(r, 32'h0);
        wt <= 1'b0;
        ax <= 1'b1;
        count_sel(0);
        chk(r, 32'h0);
        ax <= 1'b0;
        $display("test select clock done");
        exec_n <= 1'b0;
        io_n <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            opn <= ~4'(i);
            repeat (2) @(posedge clk);
            chk(csel, 32'h1 << i);
        end
        exec_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk(csel, 32'h0);
        $display("test decoder done");
        summarize;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            err_count++;
            summarize;
        end
    end
endmodule // tb
`default_nettype wire
